/* rtl/pdsf_pkg.sv */
/*
   Shared constants: mode codes, cycle table, limits, reset values.
   Assumes nothing; used as pdsf_pkg::name.
*/
package pdsf_pkg;

   // Port mode codes
   localparam logic [2:0] PM_OFF    = 3'h0;
   localparam logic [2:0] PM_MANUAL = 3'h1;
   localparam logic [2:0] PM_AUTO   = 3'h2;
   localparam logic [2:0] PM_DIN    = 3'h3;
   localparam logic [2:0] PM_DOUT   = 3'h4;

   // Validation and storage levels
   localparam logic [2:0] LV_NONE     = 3'h0;
   localparam logic [2:0] LV_V10      = 3'h1;
   localparam logic [2:0] LV_V11      = 3'h2;
   localparam logic [2:0] LV_V11_BR   = 3'h3;
   localparam logic [2:0] LV_V11_REST = 3'h4;

   // Second pin functions
   localparam logic [1:0] SP_OFF  = 2'h0;
   localparam logic [1:0] SP_DIN  = 2'h1;
   localparam logic [1:0] SP_DOUT = 2'h2;

   // Output fallback behaviours
   localparam logic [2:0] FB_LOW  = 3'h0;
   localparam logic [2:0] FB_HIGH = 3'h1;
   localparam logic [2:0] FB_HOLD = 3'h2;
   localparam logic [2:0] FB_REPL = 3'h3;
   localparam logic [2:0] FB_CMD  = 3'h4;

   // Swap mode ranges
   localparam logic [4:0] SW_RAW      = 5'h00;
   localparam logic [4:0] SW_WORD_MAX = 5'h10;
   localparam logic [4:0] SW_DW_BASE  = 5'h10;
   localparam logic [4:0] SW_DW_MAX   = 5'h18;

   // Cycle selector, periods in us
   localparam logic [3:0] CT_FASTEST = 4'h0;
   localparam logic [3:0] CT_MAX_SEL = 4'h8;
   localparam int CT_1_US = 1600;
   localparam int CT_2_US = 3200;
   localparam int CT_3_US = 4800;
   localparam int CT_4_US = 8000;
   localparam int CT_5_US = 20800;
   localparam int CT_6_US = 40000;
   localparam int CT_7_US = 80000;
   localparam int CT_8_US = 120000;

   // Byte limits
   localparam int MAX_OD_BYTES = 32;
   localparam int BYTE_W       = 8;

   // Reset values
   localparam logic [5:0] OUT_SIZE_RST = 6'h00;

endpackage : pdsf_pkg

/* rtl/pdsf_port.sv */
/*
   Per-port policy of an IO-Link master port:
   identity check, storage control, second pin,
   cycle time, byte swap, output fallback, size
   limit, 16-word FIFO on host output data.
   Assumes inputs on CLOCK except PIN2_IN,
   an asynchronous pin. An outside sequencer
   does the storage transfers and answers DS_XFER_DONE.
*/
// Function
// - Erase backup on factory reset, mode change or level change; an upload done in the same cycle keeps it.
// - Level, cycle time and identifiers apply only in manual mode.
// - Level 0: no identity check, no backup or restore.
// - V1.0 level: check identity, no storage.
// - V1.1 level: check identity, storage off.
// - Backup level, connect without valid set: upload and keep it.
// - Backup level: upload on the device upload flag.
// - Valid set differing from device on connect: download it.
// - Restore-only: never store; upload flag triggers a download.
// - Cycle time fastest common or fixed 1.6 to 120.0 ms.
// - Pin output from control bit or first output byte.
// - Pin input state reported in input status.
// - Swap raw, up to 16 words, or up to 8 dwords.
// - Swap offset sets first swapped byte, bounded by output size.
// - Fallback on internal error, stop, broken connection or lost link.
// - Fallback drives outputs low, high or holds the last.
// - Replacement sends up to 32 bytes, limited to output size.
// - Replacement bytes pass the swap stage.
// - Master-command mode flags output invalid; device decides.
// - Output size up to 32 bytes, counts toward connection total.
// - Output size change refused during host connection.
// - Levels 0 none, 1 V1.0, 2 V1.1, 3 backup, 4 restore.
// - Cycle selector 0 fastest, 1..8 for 1.6 to 120.0 ms.
// - Fallback 0 low, 1 high, 2 hold, 3 replacement; hold default.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Output data FIFO
module pdsf_fifo #(
   parameter int WIDTH = 256,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
         $error("pdsf_fifo: DEPTH must be a power of two >= 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } pdsf_fifo_t;

   pdsf_fifo_t s_q;
   pdsf_fifo_t s_d;
   logic       push;
   logic       pop;

   // Flags from the count
   assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data  = s_q.mem[s_q.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and count update
   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wr] = in_data;
         s_d.wr          = s_q.wr + 1'b1;
      end
      if (pop)
         s_d.rd = s_q.rd + 1'b1;
      if (push && !pop)
         s_d.cnt = s_q.cnt + 1'b1;
      else if (pop && !push)
         s_d.cnt = s_q.cnt - 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule // pdsf_fifo

////////////////////////////////////////////////////////////////////////////////
// Port policy top
module pdsf_port #(
   parameter int OD_BYTES   = 32,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input  wire logic                  CLOCK,
   input  wire logic                  RESET,
   // Port configuration
   input  wire logic [2:0]            PORT_MODE,
   input  wire logic [2:0]            VALIDATION_LEVEL,
   input  wire logic [3:0]            CYCLE_SEL,
   input  wire logic [15:0]           EXP_VENDOR_ID,
   input  wire logic [23:0]           EXP_DEVICE_ID,
   input  wire logic                  FACTORY_RESET,
   // Second pin
   input  wire logic [1:0]            SECOND_PIN_FUNCTION,
   input  wire logic                  DO_FROM_PROCESS,
   input  wire logic                  DO_CONTROL_BIT,
   input  wire logic                  PIN2_IN,
   output logic                       PIN2_OUT,
   output logic                       PIN2_OE,
   output logic                       DI_STATUS,
   // Cycle time
   output logic [3:0]                 CYCLE_SEL_EFF,
   output logic [16:0]                CYCLE_PERIOD_US,
   // Swapping and fallback
   input  wire logic [4:0]            SWAP_MODE,
   input  wire logic [4:0]            SWAP_OFFSET,
   input  wire logic [2:0]            OUTPUT_FALLBACK_BEHAVIOUR,
   input  wire logic [OD_BYTES*8-1:0] REPL_DATA,
   input  wire logic                  INTERNAL_ERROR,
   input  wire logic                  CTRL_STOP,
   input  wire logic                  CONN_BROKEN,
   input  wire logic                  COMM_LOST,
   output logic                       FALLBACK_ACTIVE,
   // Output size
   input  wire logic [5:0]            OUT_SIZE_REQ,
   input  wire logic                  OUT_SIZE_WR,
   input  wire logic                  HOST_CONN_ACTIVE,
   output logic [5:0]                 OUT_SIZE,
   output logic                       OUT_SIZE_REJECT,
   // Host output data stream
   input  wire logic                  HOST_OD_VALID,
   output logic                       HOST_OD_READY,
   input  wire logic [OD_BYTES*8-1:0] HOST_OD_DATA,
   // Device output frame
   output logic                       TX_VALID,
   input  wire logic                  TX_READY,
   output logic [OD_BYTES*8-1:0]      TX_DATA,
   output logic                       TX_OD_INVALID,
   // Device identity and data storage
   input  wire logic                  DEV_CONNECT,
   input  wire logic [15:0]           DEV_VENDOR_ID,
   input  wire logic [23:0]           DEV_DEVICE_ID,
   input  wire logic                  DEV_UPLOAD_FLAG,
   input  wire logic                  DEV_PARAMS_DIFFER,
   input  wire logic                  DS_XFER_DONE,
   output logic                       ID_MISMATCH,
   output logic                       DS_VALID,
   output logic                       DS_UPLOAD_START,
   output logic                       DS_DOWNLOAD_START,
   output logic                       DS_CLEAR
);
   localparam int ODW = OD_BYTES * pdsf_pkg::BYTE_W;

   initial
   begin
      if (OD_BYTES < 1 || OD_BYTES > pdsf_pkg::MAX_OD_BYTES)
         $error("pdsf_port: OD_BYTES must lie in 1..32");
   end

   typedef enum logic [1:0] {
      DS_IDLE = 2'b00,
      DS_UP   = 2'b01,
      DS_DOWN = 2'b10
   } pdsf_ds_t;

   typedef struct packed {
      pdsf_ds_t        ds;
      logic [2:0]      mode_prev;
      logic [2:0]      lvl_prev;
      logic            ds_valid;
      logic            clear;
      logic            up_start;
      logic            dn_start;
      logic            id_bad;
      logic [5:0]      out_size;
      logic            size_rej;
      logic            tx_valid;
      logic [ODW-1:0]  tx_data;
      logic            tx_inval;
      logic [ODW-1:0]  last;
      logic [1:0]      din_sync;
      logic            pin2_do;
   } pdsf_state_t;

   pdsf_state_t s_q;
   pdsf_state_t s_d;

   logic           fifo_valid;
   logic           fifo_pop;
   logic [ODW-1:0] fifo_data;
   logic           manual;
   logic [2:0]     lvl_eff;
   logic           fallback;
   logic           store_on;
   logic           load_tx;

   //////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Byte swap inside the size window
   function automatic logic [ODW-1:0] swap_bytes(input logic [ODW-1:0] d,
                                                 input logic [4:0]     mode,
                                                 input logic [4:0]     off,
                                                 input logic [5:0]     size);
      logic [ODW-1:0] r;
      int             p;
      int             src;
      int             span;
      r = '0;
      span = 0;
      if (mode != pdsf_pkg::SW_RAW && mode <= pdsf_pkg::SW_WORD_MAX)
         span = 2 * int'(mode);
      else if (mode > pdsf_pkg::SW_DW_BASE && mode <= pdsf_pkg::SW_DW_MAX)
         span = 4 * int'(mode - pdsf_pkg::SW_DW_BASE);
      // Clip to whole groups inside size
      if (int'(off) + span > int'(size))
         span = (mode > pdsf_pkg::SW_DW_BASE) ? ((int'(size) - int'(off)) / 4) * 4
                                              : ((int'(size) - int'(off)) / 2) * 2;
      for (int i = 0; i < OD_BYTES; i++)
      begin
         p   = i - int'(off);
         src = i;
         if (p >= 0 && p < span)
            src = (mode > pdsf_pkg::SW_DW_BASE) ? int'(off) + (p & ~3) + 3 - (p & 3)
                                                : int'(off) + (p ^ 1);
         if (i < int'(size))
            r[i*8 +: 8] = d[src*8 +: 8];
      end
      return r;
   endfunction

   // Fixed period; zero means fastest
   function automatic logic [16:0] cycle_us(input logic [3:0] sel);
      case (sel)
         4'h1:    cycle_us = 17'(pdsf_pkg::CT_1_US);
         4'h2:    cycle_us = 17'(pdsf_pkg::CT_2_US);
         4'h3:    cycle_us = 17'(pdsf_pkg::CT_3_US);
         4'h4:    cycle_us = 17'(pdsf_pkg::CT_4_US);
         4'h5:    cycle_us = 17'(pdsf_pkg::CT_5_US);
         4'h6:    cycle_us = 17'(pdsf_pkg::CT_6_US);
         4'h7:    cycle_us = 17'(pdsf_pkg::CT_7_US);
         4'h8:    cycle_us = 17'(pdsf_pkg::CT_8_US);
         default: cycle_us = 17'h00000;
      endcase
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // Host buffer, drained via load_tx
   pdsf_fifo #(
      .WIDTH (ODW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLOCK),
      .rst       (RESET),
      .in_valid  (HOST_OD_VALID),
      .in_ready  (HOST_OD_READY),
      .in_data   (HOST_OD_DATA),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   //////////////////////////////////////////////////////////////////////////////
   // Effective configuration
   // manual mode gate
   assign manual   = (PORT_MODE == pdsf_pkg::PM_MANUAL);
   assign lvl_eff  = manual ? VALIDATION_LEVEL : pdsf_pkg::LV_NONE;
   // storage only at levels 3 and 4
   assign store_on = (lvl_eff == pdsf_pkg::LV_V11_BR || lvl_eff == pdsf_pkg::LV_V11_REST)
                     && !s_q.id_bad;
   assign fallback = INTERNAL_ERROR || CTRL_STOP || CONN_BROKEN || COMM_LOST;
   assign load_tx  = !s_q.tx_valid || TX_READY;
   // Stale frames drop in fallback
   assign fifo_pop = fifo_valid && load_tx;

   //////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      s_d          = s_q;
      s_d.clear    = 1'b0;
      s_d.up_start = 1'b0;
      s_d.dn_start = 1'b0;
      s_d.size_rej = 1'b0;
      s_d.mode_prev = PORT_MODE;
      s_d.lvl_prev  = VALIDATION_LEVEL;

      s_d.din_sync = {s_q.din_sync[0], PIN2_IN};

      if (DEV_CONNECT)
         s_d.id_bad = (lvl_eff != pdsf_pkg::LV_NONE) &&
                      (DEV_VENDOR_ID != EXP_VENDOR_ID || DEV_DEVICE_ID != EXP_DEVICE_ID);

      case (s_q.ds)
         DS_IDLE:
         begin
            if (store_on && DEV_CONNECT)
            begin
               if (!s_q.ds_valid && lvl_eff == pdsf_pkg::LV_V11_BR)
               begin
                  s_d.ds       = DS_UP;
                  s_d.up_start = 1'b1;
               end
               else if (s_q.ds_valid && DEV_PARAMS_DIFFER)
               begin
                  s_d.ds       = DS_DOWN;
                  s_d.dn_start = 1'b1;
               end
            end
            else if (store_on && DEV_UPLOAD_FLAG)
            begin
               if (lvl_eff == pdsf_pkg::LV_V11_BR)
               begin
                  s_d.ds       = DS_UP;
                  s_d.up_start = 1'b1;
               end
               else if (s_q.ds_valid)
               begin
                  s_d.ds       = DS_DOWN;
                  s_d.dn_start = 1'b1;
               end
            end
         end
         DS_UP:
            if (DS_XFER_DONE)
               s_d.ds = DS_IDLE;
         DS_DOWN:
            if (DS_XFER_DONE)
               s_d.ds = DS_IDLE;
         default:
            s_d.ds = DS_IDLE;
      endcase

      // erase; a same-cycle upload done wins
      if (FACTORY_RESET || PORT_MODE != s_q.mode_prev || VALIDATION_LEVEL != s_q.lvl_prev)
      begin
         s_d.clear    = 1'b1;
         s_d.ds_valid = 1'b0;
         s_d.ds       = DS_IDLE;
         s_d.up_start = 1'b0;
         s_d.dn_start = 1'b0;
      end
      if (s_q.ds == DS_UP && DS_XFER_DONE)
         s_d.ds_valid = 1'b1;

      // output size write guarded by connection
      if (OUT_SIZE_WR)
      begin
         if (HOST_CONN_ACTIVE || OUT_SIZE_REQ > 6'(OD_BYTES))
            s_d.size_rej = 1'b1;
         else
            s_d.out_size = OUT_SIZE_REQ;
      end

      // Frame register toward the device
      if (TX_READY)
         s_d.tx_valid = 1'b0;
      if (load_tx)
      begin
         if (fallback)
         begin
            s_d.tx_valid = 1'b1;
            s_d.tx_inval = 1'b0;
            case (OUTPUT_FALLBACK_BEHAVIOUR)
               pdsf_pkg::FB_LOW:
                  s_d.tx_data = '0;
               pdsf_pkg::FB_HIGH:
                  s_d.tx_data = swap_bytes('1, pdsf_pkg::SW_RAW, 5'h00, s_q.out_size);
               // replacement bytes through the swap stage
               pdsf_pkg::FB_REPL:
                  s_d.tx_data = swap_bytes(REPL_DATA, SWAP_MODE, SWAP_OFFSET, s_q.out_size);
               // mark data invalid, keep last frame
               pdsf_pkg::FB_CMD:
               begin
                  s_d.tx_data  = swap_bytes(s_q.last, SWAP_MODE, SWAP_OFFSET, s_q.out_size);
                  s_d.tx_inval = 1'b1;
               end
               default:
                  s_d.tx_data = swap_bytes(s_q.last, SWAP_MODE, SWAP_OFFSET, s_q.out_size);
            endcase
         end
         else if (fifo_valid)
         begin
            s_d.tx_valid = 1'b1;
            s_d.tx_inval = 1'b0;
            s_d.tx_data  = swap_bytes(fifo_data, SWAP_MODE, SWAP_OFFSET, s_q.out_size);
            s_d.last     = fifo_data;
            s_d.pin2_do  = fifo_data[0];
         end
      end
   end

   // State register
   always_ff @(posedge CLOCK or posedge RESET)
   begin
      if (RESET)
      begin
         s_q           <= '0;
         s_q.ds        <= DS_IDLE;
         s_q.mode_prev <= pdsf_pkg::PM_DIN;
         s_q.out_size  <= pdsf_pkg::OUT_SIZE_RST;
      end
      else
         s_q <= s_d;
   end

   //////////////////////////////////////////////////////////////////////////////
   // Outputs
   // cycle time effective only in manual mode
   assign CYCLE_SEL_EFF   = (manual && CYCLE_SEL <= pdsf_pkg::CT_MAX_SEL) ? CYCLE_SEL
                                                                          : pdsf_pkg::CT_FASTEST;
   assign CYCLE_PERIOD_US = cycle_us(CYCLE_SEL_EFF);
   assign PIN2_OE         = (SECOND_PIN_FUNCTION == pdsf_pkg::SP_DOUT);
   assign PIN2_OUT        = PIN2_OE && (DO_FROM_PROCESS ? s_q.pin2_do : DO_CONTROL_BIT);
   assign DI_STATUS       = (SECOND_PIN_FUNCTION == pdsf_pkg::SP_DIN) && s_q.din_sync[1];
   assign FALLBACK_ACTIVE = fallback;
   assign OUT_SIZE        = s_q.out_size;
   assign OUT_SIZE_REJECT = s_q.size_rej;
   assign TX_VALID        = s_q.tx_valid;
   assign TX_DATA         = s_q.tx_data;
   assign TX_OD_INVALID   = s_q.tx_inval;
   assign ID_MISMATCH     = s_q.id_bad;
   assign DS_VALID        = s_q.ds_valid;
   assign DS_UPLOAD_START   = s_q.up_start;
   assign DS_DOWNLOAD_START = s_q.dn_start;
   assign DS_CLEAR          = s_q.clear;
endmodule // pdsf_port

`default_nettype wire

/* bench/pdsf_properties.sv */
/* Port properties of pdsf_port.
   Assumes one clock; bound to each instance. */
`timescale 1ns/1ps
`default_nettype none
module pdsf_properties (
   // Single bits
   input wire logic       CLOCK, RESET, FACTORY_RESET, OUT_SIZE_WR, HOST_CONN_ACTIVE,
   input wire logic       INTERNAL_ERROR, CTRL_STOP, CONN_BROKEN, COMM_LOST, FALLBACK_ACTIVE,
   input wire logic       PIN2_OE, DI_STATUS, OUT_SIZE_REJECT, DS_VALID, TX_VALID,
   input wire logic       DS_UPLOAD_START, DS_DOWNLOAD_START, DS_CLEAR,
   // Fields
   input wire logic [2:0] PORT_MODE, VALIDATION_LEVEL,
   input wire logic [3:0] CYCLE_SEL, CYCLE_SEL_EFF,
   input wire logic [1:0] SECOND_PIN_FUNCTION,
   input wire logic [5:0] OUT_SIZE_REQ, OUT_SIZE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   // Refused writes keep the size
   chk_size_refused: assert property (
      OUT_SIZE_WR && (HOST_CONN_ACTIVE || OUT_SIZE_REQ > 6'h20) |=>
      OUT_SIZE_REJECT && $stable(OUT_SIZE)) else $error("size not refused");
   chk_size_taken: assert property (
      OUT_SIZE_WR && !HOST_CONN_ACTIVE && OUT_SIZE_REQ <= 6'h20 |=>
      OUT_SIZE == $past(OUT_SIZE_REQ) && !OUT_SIZE_REJECT) else $error("size not taken");
   chk_fallback_cause: assert property (
      FALLBACK_ACTIVE == (INTERNAL_ERROR || CTRL_STOP || CONN_BROKEN || COMM_LOST))
      else $error("fallback wrong");
   // Cycle selector counts only in manual mode
   chk_cycle_manual: assert property (
      CYCLE_SEL_EFF == ((PORT_MODE == 3'h1 && CYCLE_SEL <= 4'h8) ? CYCLE_SEL : 4'h0))
      else $error("cycle wrong");
   chk_pin_drive: assert property (
      PIN2_OE == (SECOND_PIN_FUNCTION == 2'h2)) else $error("pin wrong");
   chk_din_gate: assert property (
      DI_STATUS |-> SECOND_PIN_FUNCTION == 2'h1) else $error("status ungated");
   // Starts only where storage allows
   chk_upload_level: assert property (
      DS_UPLOAD_START |-> $past(VALIDATION_LEVEL) == 3'h3 && $past(PORT_MODE) == 3'h1)
      else $error("bad upload");
   chk_download_set: assert property (
      DS_DOWNLOAD_START |-> $past(DS_VALID) && $past(VALIDATION_LEVEL) >= 3'h3)
      else $error("bad download");
   chk_erase_event: assert property (
      FACTORY_RESET || $changed(PORT_MODE) || $changed(VALIDATION_LEVEL) |=> DS_CLEAR)
      else $error("not erased");
   cover property (DS_UPLOAD_START);
   cover property (DS_DOWNLOAD_START);
   cover property (OUT_SIZE_REJECT);
   cover property (FALLBACK_ACTIVE && TX_VALID);
endmodule // pdsf_properties
bind pdsf_port pdsf_properties pdsf_properties_i (.*);
`default_nettype wire

/* bench/pdsf_dev_model.sv */
/* Device: takes frames, answers storage transfers.
   Assumes slow from the bench. */
`timescale 1ns/1ps
`default_nettype none
module pdsf_dev_model (
   // Clock, reset and pacing
   input  wire logic clk, rst, slow,
   // Storage requests and answers
   input  wire logic up_start, dn_start,
   output logic      tx_ready, xfer_done
);
   logic [2:0] pace_q;
   logic [1:0] busy_q;
   // Slow: one frame in eight, FIFO fills
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         pace_q <= 3'h0;
         busy_q <= 2'h0;
         tx_ready <= 1'b0;
         xfer_done <= 1'b0;
      end
      else
      begin
         pace_q <= pace_q + 3'h1;
         tx_ready <= !slow || pace_q == 3'h0;
         xfer_done <= busy_q == 2'h1;
         busy_q <= (up_start || dn_start) ? 2'h3 : busy_q - {1'b0, busy_q != 2'h0};
      end
endmodule // pdsf_dev_model
`default_nettype wire

/* bench/pdsf_port_bench.sv */
/* Bench of pdsf_port: random frames, corners.
   Assumes the device model and checker. */
`timescale 1ns/1ps
`default_nettype none
module pdsf_port_bench;
   logic CLOCK=1'b0, RESET=1'b1, FACTORY_RESET=1'b0, PIN2_IN=1'b0, DO_FROM_PROCESS=1'b0;
   logic DO_CONTROL_BIT=1'b0, INTERNAL_ERROR=1'b0, CTRL_STOP=1'b0, CONN_BROKEN=1'b0;
   logic COMM_LOST=1'b0, OUT_SIZE_WR=1'b0, HOST_CONN_ACTIVE=1'b0, HOST_OD_VALID=1'b0;
   logic DEV_CONNECT=1'b0, DEV_UPLOAD_FLAG=1'b0, DEV_PARAMS_DIFFER=1'b0, slow=1'b0;
   logic fmode=1'b0, seen=1'b0, PIN2_OUT, PIN2_OE, DI_STATUS, FALLBACK_ACTIVE, TX_VALID;
   logic OUT_SIZE_REJECT, HOST_OD_READY, TX_READY, TX_OD_INVALID, ID_MISMATCH, DS_VALID;
   logic DS_UPLOAD_START, DS_DOWNLOAD_START, DS_CLEAR, DS_XFER_DONE;
   logic [2:0]   PORT_MODE = 3'h1, VALIDATION_LEVEL = 3'h0, OUTPUT_FALLBACK_BEHAVIOUR = 3'h2;
   logic [3:0]   CYCLE_SEL = 4'h0, CYCLE_SEL_EFF;
   logic [1:0]   SECOND_PIN_FUNCTION = 2'h0;
   logic [4:0]   SWAP_MODE = 5'h00, SWAP_OFFSET = 5'h00;
   logic [5:0]   OUT_SIZE_REQ = 6'h00, OUT_SIZE;
   logic [16:0]  CYCLE_PERIOD_US;
   // Arbitrary identity values
   logic [15:0]  EXP_VENDOR_ID = 16'h5a3c, DEV_VENDOR_ID = 16'h0001;
   logic [23:0]  EXP_DEVICE_ID = 24'h00c0de, DEV_DEVICE_ID = 24'h00c0de;
   logic [255:0] REPL_DATA = '0, HOST_OD_DATA = '0, TX_DATA, last = '0, q[$];
   logic [31:0]  lfsr = 32'h00010f46;
   int           num_errors = 0, compares = 0;
   int           per[9] = '{0,1600,3200,4800,8000,20800,40000,80000,120000};
   pdsf_port pdsf_port_i (.*);
   pdsf_dev_model pdsf_dev_model_i (.clk(CLOCK), .rst(RESET), .slow(slow),
      .up_start(DS_UPLOAD_START), .dn_start(DS_DOWNLOAD_START),
      .tx_ready(TX_READY), .xfer_done(DS_XFER_DONE));
   initial forever #5 CLOCK = ~CLOCK;
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   // Swap whole groups below size, blank the rest
   function automatic logic [255:0] swp(logic [255:0] d, logic [4:0] m, o, logic [5:0] s);
      logic [255:0] r;
      int w, n, a;
      r = d;
      w = (m > 16) ? 4 : 2;
      n = (m > 16) ? m - 16 : m;
      for (int k = 0; k < n; k++)
      begin
         a = o + w * k;
         if (a + w <= s)
            for (int j = 0; j < w; j++)
               r[8*(a+j) +: 8] = d[8*(a+w-1-j) +: 8];
      end
      for (int i = 0; i < 32; i++)
         if (i >= s)
            r[8*i +: 8] = 8'h00;
      return r;
   endfunction
   function automatic logic [255:0] fbx(int b);
      case (b)
         0: return '0;
         1: return swp('1, 5'h00, 5'h00, OUT_SIZE);
         3: return swp(REPL_DATA, SWAP_MODE, SWAP_OFFSET, OUT_SIZE);
         default: return swp(last, SWAP_MODE, SWAP_OFFSET, OUT_SIZE);
      endcase
   endfunction
   task automatic chk(string nm, logic [255:0] s, logic [255:0] e);
      compares++;
      if (s !== e)
      begin
         num_errors++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic complete_run();
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask
   task automatic wdone();
      for (int t = 0; t < 20 && DS_XFER_DONE !== 1'b1; t++)
         tick(1);
      tick(1);
   endtask
   task automatic wsz(logic [5:0] r, logic c);
      logic [5:0] old;
      logic       bad;
      old = OUT_SIZE;
      bad = c || r > 6'h20;
      OUT_SIZE_REQ = r;
      HOST_CONN_ACTIVE = c;
      OUT_SIZE_WR = 1'b1;
      tick(1);
      OUT_SIZE_WR = 1'b0;
      HOST_CONN_ACTIVE = 1'b0;
      chk("reject", OUT_SIZE_REJECT, bad);
      chk("size", OUT_SIZE, bad ? old : r);
      tick(1);
   endtask
   task automatic conn(logic eu, logic ed, logic ei);
      DEV_CONNECT = 1'b1;
      tick(1);
      DEV_CONNECT = 1'b0;
      chk("upload", DS_UPLOAD_START, eu);
      chk("download", DS_DOWNLOAD_START, ed);
      chk("mismatch", ID_MISMATCH, ei);
   endtask
   // Hold valid and data to the accepting edge
   task automatic push(logic [255:0] d);
      HOST_OD_DATA = d;
      HOST_OD_VALID = 1'b1;
      for (int t = 0; t < 300 && HOST_OD_READY !== 1'b1; t++)
      begin
         seen = 1'b1;
         tick(1);
      end
      q.push_back(swp(d, SWAP_MODE, SWAP_OFFSET, OUT_SIZE));
      last = d;
      tick(1);
   endtask
   // Frames in host order
   always @(posedge CLOCK)
      if (TX_VALID && TX_READY && !fmode && q.size() > 0)
         chk("frame", TX_DATA, q.pop_front());
   initial
   begin
      #200000;
      num_errors++;
      complete_run();
   end
   initial
   begin
      REPL_DATA = {8{rnd()}};
      tick(20);
      RESET = 1'b0;
      tick(3);
      wsz(6'h21, 1'b0);
      wsz(6'h20, 1'b0);
      wsz(6'h08, 1'b1);
      for (int i = 0; i < 10; i++)
      begin
         CYCLE_SEL = 4'(i);
         tick(1);
         chk("period", CYCLE_PERIOD_US, (i > 8) ? 0 : per[i]);
      end
      // Levels without storage
      for (int l = 0; l < 3; l++)
      begin
         VALIDATION_LEVEL = 3'(l);
         tick(2);
         conn(1'b0, 1'b0, l != 0);
      end
      DEV_VENDOR_ID = EXP_VENDOR_ID;
      conn(1'b0, 1'b0, 1'b0);
      VALIDATION_LEVEL = 3'h3;
      tick(2);
      conn(1'b1, 1'b0, 1'b0);
      wdone();
      chk("valid", DS_VALID, 1'b1);
      // Flag after a store request
      DEV_UPLOAD_FLAG = 1'b1;
      tick(1);
      DEV_UPLOAD_FLAG = 1'b0;
      chk("flag", DS_UPLOAD_START, 1'b1);
      wdone();
      DEV_PARAMS_DIFFER = 1'b1;
      conn(1'b0, 1'b1, 1'b0);
      wdone();
      FACTORY_RESET = 1'b1;
      tick(1);
      FACTORY_RESET = 1'b0;
      chk("clear", DS_CLEAR, 1'b1);
      tick(1);
      chk("erased", DS_VALID, 1'b0);
      VALIDATION_LEVEL = 3'h4;
      tick(2);
      DEV_UPLOAD_FLAG = 1'b1;
      conn(1'b0, 1'b0, 1'b0);
      DEV_UPLOAD_FLAG = 1'b0;
      SECOND_PIN_FUNCTION = 2'h2;
      DO_CONTROL_BIT = 1'b1;
      tick(1);
      chk("pin", PIN2_OUT, 1'b1);
      SECOND_PIN_FUNCTION = 2'h1;
      PIN2_IN = 1'b1;
      tick(4);
      chk("din", DI_STATUS, 1'b1);
      // Swap corners, random ones; odd rounds stall
      for (int r = 0; r < 6; r++)
      begin
         SWAP_MODE = (r == 0) ? 5'h10 : (r == 1) ? 5'h18 : 5'(rnd() % 25);
         SWAP_OFFSET = 5'(rnd());
         wsz(6'(rnd() % 33), 1'b0);
         slow = r[0];
         seen = 1'b0;
         for (int k = 0; k < 24; k++)
            push({8{rnd()}});
         HOST_OD_VALID = 1'b0;
         tick(250);
         chk("drained", q.size(), 0);
         chk("full", seen, r[0]);
      end
      // Each behaviour, causes in turn
      fmode = 1'b1;
      slow = 1'b0;
      for (int b = 0; b < 5; b++)
      begin
         OUTPUT_FALLBACK_BEHAVIOUR = 3'(b);
         {INTERNAL_ERROR, CTRL_STOP, CONN_BROKEN, COMM_LOST} = 4'h1 << (b % 4);
         tick(4);
         chk("fallback", TX_DATA, fbx(b));
         chk("invalid", TX_OD_INVALID, b == 4);
      end
      {INTERNAL_ERROR, CTRL_STOP, CONN_BROKEN, COMM_LOST} = 4'h0;
      tick(3);
      fmode = 1'b0;
      push({8{rnd()}});
      HOST_OD_VALID = 1'b0;
      tick(10);
      chk("resume", q.size(), 0);
      DO_FROM_PROCESS = 1'b1;
      SECOND_PIN_FUNCTION = 2'h2;
      tick(1);
      chk("pin_od", PIN2_OUT, last[0]);
      complete_run();
   end
endmodule // pdsf_port_bench
`default_nettype wire
